/* dsrreg_ctrl.sv */
`timescale 1ns/1ps
`include "dsrreg_defines.svh"
// ----------------------------------------
// ----------------------------------------
module dsrreg_ctrl
  import dsrreg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic fifo_overrun_in,
  input wire logic fifo_underrun_in,
  input wire logic link_up_in,
  input wire logic video_off_in,
  input wire logic horiz_sync_in,
  input wire logic vert_sync_in,
  input wire logic data_enable_in,
  input wire logic rec_clk_in,
  input wire logic self_test_clk_pin_in,
  input wire logic aux_gpio_zero_in,
  input wire logic aux_gpio_zero_filt_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic sync_timing_out,
  output logic horiz_sync_out,
  output logic vert_sync_out,
  output logic data_enable_out,
  output logic dither_stage_a_en_out,
  output logic dither_stage_b_en_out,
  output logic hi_dither_a_en_out,
  output logic hi_dither_b_en_out,
  output dsrreg_page_t page_out,
  output logic white_balance_en_out,
  output logic table_reload_en_out,
  output logic fifo_err_clr_out,
  output logic i2s_rising_edge_out,
  output logic pixel_clk_sel_out,
  output logic pixel_clk_out,
  output logic rx_lock_out,
  output logic back_chan_out,
  output dsrreg_lane_t rx_lane_mode_out,
  output logic port_a_wr_out,
  output logic port_b_wr_out,
  output logic [7:0] eq_test_a_out,
  output logic [7:0] eq_test_b_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] timing_r;
  logic [7:0] colour_r;
  logic [7:0] audio_r;
  logic [7:0] pclk_r;
  logic [7:0] rxctl_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic err_clr_r;
  dsrreg_state_t state_r;
  dsrreg_state_t state_nxt;
  logic overrun_flag;
  logic underrun_flag;
  logic [7:0] eq_rd;
  logic [7:0] eq_a;
  logic [7:0] eq_b;
  logic [5:0] out_r;
  logic [5:0] out_nxt;
  logic [1:0] portwr_r;
  logic [1:0] hi_en_r;
  logic [7:0] rd_mux;

  // Address decode, shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // Register selects
  // ----------------------------------------
  // One compare per register; write strobes, read mux and sequencer share them
  // Unmapped offsets hit nothing, so they read zero and write nowhere
  wire sel_timing = hit(addr_in, `DSRREG_OFS_TIMING);
  wire sel_colour = hit(addr_in, `DSRREG_OFS_COLOUR);
  wire sel_audio = hit(addr_in, `DSRREG_OFS_AUDIO);
  wire sel_pclk = hit(addr_in, `DSRREG_OFS_PCLK);
  wire sel_rxctl = hit(addr_in, `DSRREG_OFS_RXCTL);
  wire sel_eq = hit(addr_in, `DSRREG_OFS_EQTEST);

  wire wr_timing = wr_en_in & sel_timing;
  wire wr_colour = wr_en_in & sel_colour;
  wire wr_audio = wr_en_in & sel_audio;
  wire wr_pclk = wr_en_in & sel_pclk;
  wire wr_rxctl = wr_en_in & sel_rxctl;
  wire wr_eq = wr_en_in & sel_eq;
  wire port_b_sel = rxctl_r[`DSRREG_BIT_PORT_B];
  wire port_a_sel = rxctl_r[`DSRREG_BIT_PORT_A];

  wire err_clr = wr_audio & wr_data_in[`DSRREG_BIT_ERR_RST];

  // ----------------------------------------
  // Sticky audio FIFO errors
  // ----------------------------------------
  // The host sees a flag on the edge after the FIFO event
  // flags held
  dsrreg_sticky u_overrun (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .set_in(fifo_overrun_in),
    .clr_in(err_clr),
    .flag_out(overrun_flag)
  );

  dsrreg_sticky u_underrun (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .set_in(fifo_underrun_in),
    .clr_in(err_clr),
    .flag_out(underrun_flag)
  );

  // ----------------------------------------
  // Equalizer test store
  // ----------------------------------------
  // port steering
  dsrreg_eqbank u_eq (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_eq),
    .wr_port_in(port_b_sel),
    .wr_data_in(wr_data_in),
    .rd_port_in(port_b_sel),
    .rd_data_out(eq_rd),
    .port_a_out(eq_a),
    .port_b_out(eq_b)
  );

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Control registers; masks drop reserved bits
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      timing_r <= `DSRREG_RST_ZERO;
      hi_en_r <= `DSRREG_RST_HI_EN;
      colour_r <= `DSRREG_RST_ZERO;
      audio_r <= `DSRREG_RST_ZERO;
      pclk_r <= `DSRREG_RST_ZERO;
      rxctl_r <= `DSRREG_RST_RXCTL;
    end else begin
      // inverted sense held as enables, so no gate follows the flop
      if (wr_timing) begin
        timing_r <= wr_data_in & `DSRREG_WMASK_TIMING;
        hi_en_r <= ~wr_data_in[`DSRREG_BIT_HI_B_OFF:`DSRREG_BIT_HI_A_OFF];
      end
      if (wr_colour) colour_r <= wr_data_in & `DSRREG_WMASK_COLOUR;
      if (wr_audio) audio_r <= wr_data_in & `DSRREG_WMASK_AUDIO;
      if (wr_pclk) pclk_r <= wr_data_in & `DSRREG_WMASK_PCLK;
      if (wr_rxctl) rxctl_r <= wr_data_in & `DSRREG_WMASK_RXCTL;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // overrun bit, underrun bit; unmapped reads zero
  assign rd_mux =
    sel_timing ? timing_r :
    sel_colour ? colour_r :
    sel_audio ? {4'h0, overrun_flag, underrun_flag, audio_r[1:0]} :
    sel_pclk ? pclk_r :
    sel_rxctl ? rxctl_r : 8'h00;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  // Requests split by whether they need the memory's extra cycle
  wire rd_eq_req = rd_en_in & sel_eq;
  wire rd_reg_req = rd_en_in & ~sel_eq;
  wire seq_busy = (state_r == DSRREG_ST_READ);

  // Equalizer reads take one more cycle for the memory; a write never blocks a read
  always_comb begin
    state_nxt = DSRREG_ST_IDLE;
    unique case (state_r)
      DSRREG_ST_IDLE, DSRREG_ST_WRITE: begin
        if (rd_eq_req) state_nxt = DSRREG_ST_READ;
        else if (wr_en_in) state_nxt = DSRREG_ST_WRITE;
      end
      DSRREG_ST_READ: state_nxt = DSRREG_ST_IDLE;
      default: state_nxt = DSRREG_ST_IDLE;
    endcase
  end

  // A read in the busy cycle is refused (writes still land), so table reads need one idle cycle after
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= DSRREG_ST_IDLE;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      err_clr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Plain registers answer on the next edge, even right after a write
      rd_valid_r <= (rd_reg_req & ~seq_busy) | seq_busy;
      if (seq_busy) rd_data_r <= eq_rd;
      else if (rd_en_in) rd_data_r <= rd_mux;
      err_clr_r <= err_clr;
    end
  end

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  // polarity only; sync outputs not gated by mode or framing, just registered
  assign out_nxt[0] = horiz_sync_in ^ timing_r[`DSRREG_BIT_HORIZ_SYNC_POL];
  assign out_nxt[1] = vert_sync_in ^ timing_r[`DSRREG_BIT_VERT_SYNC_POL];
  assign out_nxt[2] = data_enable_in ^ timing_r[`DSRREG_BIT_DATA_EN_POL];
  assign out_nxt[3] = pclk_r[`DSRREG_BIT_EXT_PCLK] ? self_test_clk_pin_in : rec_clk_in;
  // lock on video, lock on link, video-off
  assign out_nxt[4] = rxctl_r[`DSRREG_BIT_LOCK_MODE] ? link_up_in : (link_up_in & ~video_off_in);
  assign out_nxt[5] = rxctl_r[`DSRREG_BIT_RAW_AUX] ? aux_gpio_zero_in : aux_gpio_zero_filt_in;

  // Pixel clock passes through a flop, so it is a sampled view only
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      out_r <= 6'h00;
      portwr_r <= 2'h0;
    end else begin
      out_r <= out_nxt;
      // port B write, port A write
      portwr_r <= {wr_en_in & port_b_sel, wr_en_in & port_a_sel};
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data_out = rd_data_r;
  assign rd_valid_out = rd_valid_r;
  assign sync_timing_out = timing_r[`DSRREG_BIT_TIMING_MODE];
  assign horiz_sync_out = out_r[0];
  assign vert_sync_out = out_r[1];
  assign data_enable_out = out_r[2];
  assign dither_stage_a_en_out = timing_r[`DSRREG_BIT_DITH_A_EN];
  assign dither_stage_b_en_out = timing_r[`DSRREG_BIT_DITH_B_EN];
  assign hi_dither_a_en_out = hi_en_r[0];
  assign hi_dither_b_en_out = hi_en_r[1];
  assign page_out = dsrreg_page_t'(colour_r[`DSRREG_BIT_PAGE_HI:`DSRREG_BIT_PAGE_LO]);
  assign white_balance_en_out = colour_r[`DSRREG_BIT_WB_EN];
  assign table_reload_en_out = colour_r[`DSRREG_BIT_RELOAD_EN];
  assign fifo_err_clr_out = err_clr_r;
  assign i2s_rising_edge_out = audio_r[`DSRREG_BIT_RISE_EDGE];
  assign pixel_clk_sel_out = pclk_r[`DSRREG_BIT_EXT_PCLK];
  assign pixel_clk_out = out_r[3];
  assign rx_lock_out = out_r[4];
  assign back_chan_out = out_r[5];
  assign rx_lane_mode_out = dsrreg_lane_t'(rxctl_r[`DSRREG_BIT_LANE_HI:`DSRREG_BIT_LANE_LO]);
  assign port_a_wr_out = portwr_r[0];
  assign port_b_wr_out = portwr_r[1];
  assign eq_test_a_out = eq_a;
  assign eq_test_b_out = eq_b;
endmodule

/* dsrreg_ctrl_asserts.sv */
`timescale 1ns/1ps
module dsrreg_ctrl_asserts
  import dsrreg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic link_up_in,
  input wire logic rd_valid_out,
  input wire logic sync_timing_out,
  input wire dsrreg_page_t page_out,
  input wire logic fifo_err_clr_out,
  input wire logic rx_lock_out,
  input wire dsrreg_lane_t rx_lane_mode_out,
  input wire logic port_a_wr_out,
  input wire logic port_b_wr_out
);
  // ----------------------------------------
  // Port protocol checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // Write request at one offset
  sequence s_wr(a);
    wr_en_in && addr_in == a;
  endsequence
  a_timing_mode: assert property (s_wr(8'h29) |=> sync_timing_out == $past(wr_data_in[7]))
    else $error("timing mode bit not applied");
  a_page_field: assert property (s_wr(8'h2A) |=> page_out == $past(wr_data_in[7:6]))
    else $error("page field not applied");
  a_lane_field: assert property (s_wr(8'h34) |=> rx_lane_mode_out == $past(wr_data_in[4:3]))
    else $error("lane mode not applied");
  a_err_clr_fires: assert property (s_wr(8'h2B) ##0 wr_data_in[1] |=> fifo_err_clr_out)
    else $error("error clear pulse missing");
  a_err_clr_cause: assert property (fifo_err_clr_out |-> $past(wr_en_in && addr_in == 8'h2B))
    else $error("error clear without write");
  a_lock_link: assert property (rx_lock_out |-> $past(link_up_in))
    else $error("lock without link");
  a_port_wr: assert property (port_a_wr_out || port_b_wr_out |-> $past(wr_en_in))
    else $error("port write pulse without write");
  a_rd_answer: assert property (rd_en_in && addr_in != 8'h35 |=> rd_valid_out)
    else $error("read answer late");
  a_eq_rd_late: assert property (rd_en_in && addr_in == 8'h35 |=> !rd_valid_out ##1 rd_valid_out)
    else $error("equalizer read answer wrong cycle");
endmodule

/* dsrreg_ctrl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("BAD %s exp %h got %h", n, e, g); fail_count++; end end
module dsrreg_ctrl_tb_top;
  import dsrreg_pkg::*;
  logic [7:0] addr_in, wr_data_in, rd_data_out, eq_test_a_out, eq_test_b_out, d;
  logic core_clk_in, rst_in, wr_en_in, rd_en_in, fifo_overrun_in, fifo_underrun_in, link_up_in, ok;
  logic video_off_in, horiz_sync_in, vert_sync_in, data_enable_in, rec_clk_in, self_test_clk_pin_in;
  logic aux_gpio_zero_in, aux_gpio_zero_filt_in, rd_valid_out, sync_timing_out, horiz_sync_out;
  logic vert_sync_out, data_enable_out, dither_stage_a_en_out, dither_stage_b_en_out, hi_dither_a_en_out;
  logic hi_dither_b_en_out, white_balance_en_out, table_reload_en_out, fifo_err_clr_out, i2s_rising_edge_out;
  logic pixel_clk_sel_out, pixel_clk_out, rx_lock_out, back_chan_out, port_a_wr_out, port_b_wr_out;
  dsrreg_page_t page_out;
  dsrreg_lane_t rx_lane_mode_out;
  int fail_count, tests_run;
  // Offsets, reset values and writable masks; 0x30 is unmapped
  localparam logic [7:0] ofs [7] = '{8'h29, 8'h2A, 8'h2B, 8'h2E, 8'h34, 8'h35, 8'h30};
  localparam logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] mask [7] = '{8'hFF, 8'hF0, 8'h03, 8'h80, 8'h7B, 8'h70, 8'h00};
  // Decoded level outputs in one word; pulse and equalizer outputs left out
  wire [18:0] outs = {sync_timing_out, dither_stage_b_en_out, dither_stage_a_en_out, hi_dither_b_en_out,
    hi_dither_a_en_out, page_out, white_balance_en_out, table_reload_en_out, i2s_rising_edge_out,
    pixel_clk_sel_out, rx_lane_mode_out, horiz_sync_out, vert_sync_out, data_enable_out, pixel_clk_out,
    back_chan_out, rx_lock_out};
  dsrreg_host_model u_dsrreg_host_model (.core_clk_in, .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out),
    .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in), .wr_data_out(wr_data_in));
  dsrreg_ctrl u_dsrreg_ctrl (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_dsrreg_host_model.wr(a, v);
  endtask
  // A missing answer ends the run at once
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_dsrreg_host_model.rd(a, d, ok);
    if (ok !== 1'b1) begin
      $display("BAD read answer exp 1 got 0");
      fail_count++;
      end_of_test();
    end else begin
      `CHK($sformatf("reg %h", a), e, d)
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    fail_count = 0;
    tests_run = 0;
    rst_in = 1'b1;
    fifo_overrun_in = 1'b0;
    fifo_underrun_in = 1'b0;
    link_up_in = 1'b1;
    video_off_in = 1'b1;
    horiz_sync_in = 1'b1;
    vert_sync_in = 1'b1;
    data_enable_in = 1'b1;
    rec_clk_in = 1'b0;
    self_test_clk_pin_in = 1'b1;
    aux_gpio_zero_in = 1'b1;
    aux_gpio_zero_filt_in = 1'b0;
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    foreach (ofs[i]) rdchk(ofs[i], rstv[i]);
    // All ones then all zeros; reserved bits must stay clear
    for (int p = 1; p >= 0; p--) begin
      foreach (ofs[i]) begin
        wr(ofs[i], p ? 8'hFF : 8'h00);
        rdchk(ofs[i], p ? mask[i] : 8'h00);
      end
      `CHK("outputs", p ? 19'h7_3FC7 : ~19'h7_3FC7, outs)
    end
    video_off_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    `CHK("lock video", 1'b1, rx_lock_out)
    link_up_in = 1'b0;
    video_off_in = 1'b1;
    wr(8'h34, 8'h41);
    `CHK("lock no link", 1'b0, rx_lock_out)
    link_up_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    `CHK("lock link", 1'b1, rx_lock_out)
    fifo_overrun_in = 1'b1;
    @(negedge core_clk_in);
    fifo_overrun_in = 1'b0;
    repeat (5) @(negedge core_clk_in);
    rdchk(8'h2B, 8'h08);
    fifo_underrun_in = 1'b1;
    @(negedge core_clk_in);
    fifo_underrun_in = 1'b0;
    rdchk(8'h2B, 8'h0C);
    wr(8'h2B, 8'h02);
    `CHK("err clr", 1'b1, fifo_err_clr_out)
    rdchk(8'h2B, 8'h02);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h70);
    `CHK("port wr a", 2'h1, {port_b_wr_out, port_a_wr_out})
    wr(8'h34, 8'h03);
    wr(8'h35, 8'h20);
    `CHK("port wr b", 2'h3, {port_b_wr_out, port_a_wr_out})
    rdchk(8'h35, 8'h20);
    `CHK("eq a", 8'h70, eq_test_a_out)
    `CHK("eq b", 8'h20, eq_test_b_out)
    wr(8'h34, 8'h01);
    rdchk(8'h35, 8'h70);
    // middle codes, then a second reset in mid-run
    wr(8'h2A, 8'h40);
    `CHK("page red", DSRREG_PAGE_RED, page_out)
    wr(8'h2A, 8'h80);
    `CHK("page green", DSRREG_PAGE_GREEN, page_out)
    wr(8'h34, 8'h0A);
    `CHK("lane dual", DSRREG_LANE_DUAL, rx_lane_mode_out)
    wr(8'h34, 8'h52);
    `CHK("lane primary", DSRREG_LANE_PRIMARY, rx_lane_mode_out)
    wr(8'h29, 8'h03);
    `CHK("hi dither off", 2'h0, {hi_dither_b_en_out, hi_dither_a_en_out})
    rst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'b0;
    rdchk(8'h34, 8'h01);
    `CHK("hi dither rst", 2'h3, {hi_dither_b_en_out, hi_dither_a_en_out})
    end_of_test();
  end
endmodule
bind dsrreg_ctrl dsrreg_ctrl_asserts u_dsrreg_ctrl_asserts (.*);

/* dsrreg_defines.svh */
`ifndef DSRREG_DEFINES_SVH
`define DSRREG_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DSRREG_OFS_TIMING 8'h29
`define DSRREG_OFS_COLOUR 8'h2A
`define DSRREG_OFS_AUDIO 8'h2B
`define DSRREG_OFS_PCLK 8'h2E
`define DSRREG_OFS_RXCTL 8'h34
`define DSRREG_OFS_EQTEST 8'h35

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSRREG_RST_ZERO 8'h00
`define DSRREG_RST_RXCTL 8'h01
`define DSRREG_RST_HI_EN 2'h3

// ----------------------------------------
// Writable masks, reserved bits are zero
// ----------------------------------------
`define DSRREG_WMASK_TIMING 8'hFF
`define DSRREG_WMASK_COLOUR 8'hF0
`define DSRREG_WMASK_AUDIO 8'h03
`define DSRREG_WMASK_PCLK 8'h80
`define DSRREG_WMASK_RXCTL 8'h7B
`define DSRREG_WMASK_EQTEST 8'h70

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSRREG_BIT_TIMING_MODE 7
`define DSRREG_BIT_HORIZ_SYNC_POL 6
`define DSRREG_BIT_VERT_SYNC_POL 5
`define DSRREG_BIT_DATA_EN_POL 4
`define DSRREG_BIT_DITH_B_EN 3
`define DSRREG_BIT_DITH_A_EN 2
`define DSRREG_BIT_HI_B_OFF 1
`define DSRREG_BIT_HI_A_OFF 0
`define DSRREG_BIT_PAGE_HI 7
`define DSRREG_BIT_PAGE_LO 6
`define DSRREG_BIT_WB_EN 5
`define DSRREG_BIT_RELOAD_EN 4
`define DSRREG_BIT_OVERRUN 3
`define DSRREG_BIT_UNDERRUN 2
`define DSRREG_BIT_ERR_RST 1
`define DSRREG_BIT_RISE_EDGE 0
`define DSRREG_BIT_EXT_PCLK 7
`define DSRREG_BIT_LOCK_MODE 6
`define DSRREG_BIT_RAW_AUX 5
`define DSRREG_BIT_LANE_HI 4
`define DSRREG_BIT_LANE_LO 3
`define DSRREG_BIT_PORT_B 1
`define DSRREG_BIT_PORT_A 0

`endif

/* dsrreg_eqbank.sv */
`timescale 1ns/1ps
`include "dsrreg_defines.svh"
// Two-word store for per-port equalizer test controls; registered read.
module dsrreg_eqbank (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic wr_port_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_port_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out
);
  logic [7:0] mem_r [0:1];
  logic [7:0] rd_r;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mem_r[0] <= `DSRREG_RST_ZERO;
      mem_r[1] <= `DSRREG_RST_ZERO;
      rd_r <= `DSRREG_RST_ZERO;
    end else begin
      if (wr_en_in) begin
        mem_r[wr_port_in] <= wr_data_in & `DSRREG_WMASK_EQTEST;
      end
      rd_r <= mem_r[rd_port_in];
    end
  end

  assign rd_data_out = rd_r;
  assign port_a_out = mem_r[0];
  assign port_b_out = mem_r[1];
endmodule

/* dsrreg_host_model.sv */
`timescale 1ns/1ps
module dsrreg_host_model (
  input wire logic core_clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out
);
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  // Idle bus at time zero
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // Data is inverted once released, so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    addr_out = a;
    wr_data_out = d;
    wr_en_out = 1'b1;
    @(negedge core_clk_in);
    wr_en_out = 1'b0;
    wr_data_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge core_clk_in);
    addr_out = a;
    rd_en_out = 1'b1;
    @(negedge core_clk_in);
    rd_en_out = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rd_valid_in) begin
        ok = 1'b1;
        d = rd_data_in;
      end else begin
        @(negedge core_clk_in);
      end
    end
  endtask
endmodule

/* dsrreg_pkg.sv */
package dsrreg_pkg;
  // Colour table page selection
  typedef enum logic [1:0] {
    DSRREG_PAGE_CFG = 2'h0,
    DSRREG_PAGE_RED = 2'h1,
    DSRREG_PAGE_GREEN = 2'h2,
    DSRREG_PAGE_BLUE = 2'h3
  } dsrreg_page_t;

  // Receive lane mode
  typedef enum logic [1:0] {
    DSRREG_LANE_AUTO = 2'h0,
    DSRREG_LANE_DUAL = 2'h1,
    DSRREG_LANE_PRIMARY = 2'h2,
    DSRREG_LANE_SECONDARY = 2'h3
  } dsrreg_lane_t;

  // Bus access state, one-hot
  typedef enum logic [2:0] {
    DSRREG_ST_IDLE = 3'b001,
    DSRREG_ST_WRITE = 3'b010,
    DSRREG_ST_READ = 3'b100
  } dsrreg_state_t;
endpackage

/* dsrreg_sticky.sv */
`timescale 1ns/1ps
// Sticky error flag: a raise in the clear cycle wins.
module dsrreg_sticky (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  logic flag_r;
  logic flag_nxt;

  // Set has priority so an event in the clear cycle survives
  assign flag_nxt = set_in | (flag_r & ~clr_in);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;
endmodule
